// *** e3oh_pkg.sv ***
// Purpose: shared constants and carriers for the e3 transmit overhead insertion block
// Assumes: e3 frame of 1536 bits, overhead bits at frame positions 0 to 11
// Notes: position counts run in the transmit (link) clock domain
package e3oh_pkg;

  // frame geometry
  localparam int unsigned POS_W = 11;
  localparam int unsigned OH_BITS = 12;
  localparam int unsigned FAS_BITS = 10;
  localparam logic [10:0] POS_LAST = 11'h5ff;    // last bit of the 1536-bit frame
  localparam logic [10:0] POS_WIN_SET = 11'h5fe; // window opens mid this bit
  localparam logic [10:0] POS_WIN_CLR = 11'h00a; // window closes mid this bit
  localparam logic [10:0] POS_N = 11'h00b;       // national bit position
  localparam logic [10:0] POS_SWAP = 11'h00c;    // first payload bit; captured bank moves on here

  // overhead bit indices
  localparam logic [3:0] IDX_A = 4'ha;
  localparam logic [3:0] IDX_LAST_FAS = 4'h9;

  // reset values and defaults
  localparam logic [9:0] FAS_DEFAULT = 10'h3d0;
  localparam logic [11:0] ACCEPT_DEFAULT = 12'hfff; // every overhead bit takes insertion

  // data-link buffer
  localparam int unsigned DLC_W = 8;
  localparam int unsigned FIFO_DEPTH = 8;
  localparam logic [3:0] DLC_BITS = 4'h8;

  // configuration carried as quasi-static levels into the link domain
  typedef struct packed {
    logic [11:0] mask;  // inverts the internally generated bit
    logic alarm;        // internal alarm bit value
    logic nat_bit;      // internal national bit value
    logic nat_dlc;      // national bit taken from the data-link buffer
  } e3oh_cfg_s;

  localparam int unsigned CFG_W = 15;

  // one bank of externally supplied overhead
  typedef struct packed {
    logic [11:0] val;
    logic [11:0] vld;
  } e3oh_ext_s;

endpackage

// *** e3oh_sync.sv ***
// Purpose: three-stage level synchroniser with agreement filter
// Assumes: input is a slow level or a toggle
// Notes: no reset; output settles within four clocks of a running clock
module e3oh_sync (
  input wire logic clk_i, // destination clock
  input wire logic d_i,   // asynchronous level
  output logic q_o        // synchronised level
);

  logic s1_q;
  logic s2_q;
  logic s3_q;
  logic out_q;

  // first stage feeds only the second one
  always_ff @(posedge clk_i) begin
    s1_q <= d_i;
    s2_q <= s1_q;
    s3_q <= s2_q;
  end

  // a change counts only once the last two stages agree
  always_ff @(posedge clk_i) begin
    if (s2_q == s3_q) begin
      out_q <= s3_q;
    end
  end

  assign q_o = out_q;

endmodule // e3oh_sync

// *** e3oh_fifo.sv ***
// Purpose: small synchronous fifo held in flip-flops
// Assumes: single clock, synchronous active-low reset
// Notes: full and empty are exact; no write while full, no read while empty
module e3oh_fifo #(
  parameter int unsigned W = 8,
  parameter int unsigned D = 8
) (
  input wire logic clk_i,          // clock
  input wire logic nrst_i,         // synchronous reset, active low
  input wire logic s_valid_i,      // write request
  output logic s_ready_o,          // room for a word
  input wire logic [W-1:0] s_data_i, // write word
  output logic m_valid_i_o,        // word available
  input wire logic m_ready_i,      // reader takes the word
  output logic [W-1:0] m_data_o    // head word
);

  localparam int unsigned AW = (D > 1) ? $clog2(D) : 1;

  logic [W-1:0] mem_q [D];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [AW:0] cnt_q;
  logic push;
  logic pop;

  assign s_ready_o = (cnt_q != (AW+1)'(D));
  assign m_valid_i_o = (cnt_q != '0);
  assign push = s_valid_i && s_ready_o;
  assign pop = m_valid_i_o && m_ready_i;
  assign m_data_o = mem_q[rd_q];

  // storage
  always_ff @(posedge clk_i) begin
    if (push) begin
      mem_q[wr_q] <= s_data_i;
    end
  end

  // pointers wrap at the depth, which need not be a power of two
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      wr_q <= '0;
      rd_q <= '0;
    end else begin
      if (push) begin
        wr_q <= (wr_q == AW'(D-1)) ? '0 : wr_q + AW'(1);
      end
      if (pop) begin
        rd_q <= (rd_q == AW'(D-1)) ? '0 : rd_q + AW'(1);
      end
    end
  end

  // occupancy
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      cnt_q <= '0;
    end else if (push && !pop) begin
      cnt_q <= cnt_q + (AW+1)'(1);
    end else if (pop && !push) begin
      cnt_q <= cnt_q - (AW+1)'(1);
    end
  end

endmodule // e3oh_fifo

// *** e3oh_tx_overhead.sv ***
// Purpose: e3 transmit overhead insertion, serial external insertion (method 1)
// Assumes: tx_clk_i is the transmit bit clock; clk_sys_i runs the data-link side
// Notes: line data leaves one transmit clock after its position is processed
module e3oh_tx_overhead
  import e3oh_pkg::*;
#(
  parameter logic [9:0] FAS_PATTERN = FAS_DEFAULT,     // alignment word, bit 9 sent first
  parameter logic [11:0] ACCEPT_MASK = ACCEPT_DEFAULT, // positions that take insertion
  parameter int unsigned FIFO_D = FIFO_DEPTH           // data-link buffer depth
) (
  input wire logic clk_sys_i,                  // system clock, 50 MHz
  input wire logic nrst_i,                     // synchronous reset, active low
  input wire logic tx_clk_i,                   // transmit bit clock (link domain)
  input wire e3oh_cfg_s cfg_i,                 // overhead configuration levels
  input wire logic dlc_valid_i,                // data-link byte offered
  input wire logic [DLC_W-1:0] dlc_data_i,     // data-link byte, msb sent first
  output logic dlc_ready_o,                    // data-link buffer has room
  input wire logic payload_bit_i,              // payload bit for this position
  output logic payload_take_o,                 // payload bit consumed this cycle
  output logic tx_data_o,                      // outbound e3 serial bit
  input wire logic overhead_data_in_i,         // external overhead bit
  input wire logic overhead_insert_enable_i,   // external insertion enable, high
  output logic overhead_clock_out_o,           // overhead clock to terminal
  output logic overhead_frame_mark_o           // high during last frame bit
);

  // ---- system domain: data-link buffer and word handshake ----

  logic fifo_valid;
  logic [DLC_W-1:0] fifo_data;
  logic pop_rdy;
  logic req_c;
  logic ack_q;
  logic [DLC_W-1:0] hold_q;
  logic req_q;

  // back-pressure reaches the source through dlc_ready_o
  e3oh_fifo #(
    .W(DLC_W),
    .D(FIFO_D)
  ) u_fifo (
    .clk_i(clk_sys_i),
    .nrst_i(nrst_i),
    .s_valid_i(dlc_valid_i),
    .s_ready_o(dlc_ready_o),
    .s_data_i(dlc_data_i),
    .m_valid_i_o(fifo_valid),
    .m_ready_i(pop_rdy),
    .m_data_o(fifo_data)
  );

  // request toggle from the link side
  e3oh_sync u_req_sync (
    .clk_i(clk_sys_i),
    .d_i(req_q),
    .q_o(req_c)
  );

  // a request is pending while the toggles differ
  assign pop_rdy = (req_c != ack_q);

  // hold word is written on the clock that ack moves; the ack synchroniser delay keeps it stable when the link reads it
  always_ff @(posedge clk_sys_i) begin
    if (!nrst_i) begin
      hold_q <= '0;
    end else if (fifo_valid && pop_rdy) begin
      hold_q <= fifo_data;
    end
  end

  // acknowledge toggle, one per delivered byte
  always_ff @(posedge clk_sys_i) begin
    if (!nrst_i) begin
      ack_q <= 1'b0;
    end else if (fifo_valid && pop_rdy) begin
      ack_q <= ~ack_q;
    end
  end

  // ---- crossings into the link domain ----

  logic link_nrst;
  logic ack_l;
  logic [CFG_W-1:0] cfg_bits;
  logic [CFG_W-1:0] cfg_l_bits;
  e3oh_cfg_s cfg_l;

  // reset reaches the link logic only through the synchroniser
  e3oh_sync u_rst_sync (
    .clk_i(tx_clk_i),
    .d_i(nrst_i),
    .q_o(link_nrst)
  );

  e3oh_sync u_ack_sync (
    .clk_i(tx_clk_i),
    .d_i(ack_q),
    .q_o(ack_l)
  );

  assign cfg_bits = cfg_i;

  // configuration bits are independent slow levels, so each crosses on its own
  for (genvar g = 0; g < CFG_W; g++) begin : g_cfg
    e3oh_sync u_cfg_sync (
      .clk_i(tx_clk_i),
      .d_i(cfg_bits[g]),
      .q_o(cfg_l_bits[g])
    );
  end

  assign cfg_l = e3oh_cfg_s'(cfg_l_bits);

  // ---- link domain: frame position ----

  logic [POS_W-1:0] pos_q;
  logic is_oh;
  logic [3:0] oh_idx;

  // free-running bit position, frames start asynchronously to anything outside
  always_ff @(posedge tx_clk_i) begin
    if (!link_nrst) begin
      pos_q <= '0;
    end else if (pos_q == POS_LAST) begin
      pos_q <= '0;
    end else begin
      pos_q <= pos_q + 11'h001;
    end
  end

  assign is_oh = (pos_q < POS_SWAP);
  assign oh_idx = pos_q[3:0];
  assign payload_take_o = !is_oh;

  // ---- link domain: overhead clock and frame mark ----

  logic win_q;
  logic mark_q;

  // window moves on the falling edge so gating never clips a high phase
  always_ff @(negedge tx_clk_i) begin
    if (!link_nrst) begin
      win_q <= 1'b0;
    end else if (pos_q == POS_WIN_SET) begin
      win_q <= 1'b1;
    end else if (pos_q == POS_WIN_CLR) begin
      win_q <= 1'b0;
    end
  end

  // one rise per overhead bit, at the start of the bit before it, for all twelve
  assign overhead_clock_out_o = tx_clk_i & win_q;

  // mark is high for the whole last bit, so the rise there is count zero
  always_ff @(posedge tx_clk_i) begin
    if (!link_nrst) begin
      mark_q <= 1'b0;
    end else begin
      mark_q <= (pos_q == POS_WIN_SET);
    end
  end

  assign overhead_frame_mark_o = mark_q;

  // ---- link domain: capture of external overhead ----

  logic [3:0] cap_idx;
  e3oh_ext_s cap_q;
  e3oh_ext_s app_q;

  // the fall during bit p carries the value for bit p+1; last bit carries bit 0
  assign cap_idx = (pos_q == POS_LAST) ? 4'h0 : (pos_q[3:0] + 4'h1);

  // each window fall rewrites its slot, so a frame without insertion clears it
  always_ff @(negedge tx_clk_i) begin
    if (!link_nrst) begin
      cap_q <= '0;
    end else if (win_q) begin
      cap_q.vld[cap_idx] <= overhead_insert_enable_i && ACCEPT_MASK[cap_idx];
      if (overhead_insert_enable_i) begin
        cap_q.val[cap_idx] <= overhead_data_in_i;
      end
    end
  end

  // captures end mid bit 10; the bank moves once the current frame's overhead is out
  always_ff @(posedge tx_clk_i) begin
    if (!link_nrst) begin
      app_q <= '0;
    end else if (pos_q == POS_SWAP) begin
      app_q <= cap_q;
    end
  end

  // ---- link domain: data-link national bits ----

  logic [DLC_W-1:0] dlc_sh_q;
  logic [3:0] dlc_cnt_q;
  logic ack_seen_q;
  logic dlc_new;

  assign dlc_new = (ack_l != ack_seen_q);

  // a fresh byte replaces the shifter; one bit leaves per frame at the national slot
  always_ff @(posedge tx_clk_i) begin
    if (!link_nrst) begin
      dlc_sh_q <= '0;
      dlc_cnt_q <= '0;
    end else if (dlc_new) begin
      dlc_sh_q <= hold_q;
      dlc_cnt_q <= DLC_BITS;
    end else if (pos_q == POS_N && cfg_l.nat_dlc && dlc_cnt_q != 4'h0 && !app_q.vld[POS_N[3:0]]) begin
      dlc_sh_q <= {dlc_sh_q[DLC_W-2:0], 1'b0};
      dlc_cnt_q <= dlc_cnt_q - 4'h1;
    end
  end

  // remember which acknowledge has been consumed
  always_ff @(posedge tx_clk_i) begin
    if (!link_nrst) begin
      ack_seen_q <= 1'b0;
    end else if (dlc_new) begin
      ack_seen_q <= ack_l;
    end
  end

  // ask for the next byte only when the shifter is empty and nothing is in flight
  always_ff @(posedge tx_clk_i) begin
    if (!link_nrst) begin
      req_q <= 1'b0;
    end else if (dlc_cnt_q == 4'h0 && !dlc_new && req_q == ack_seen_q) begin
      req_q <= ~req_q;
    end
  end

  // ---- link domain: overhead bit selection ----

  logic gen_bit;
  logic int_bit;
  logic oh_bit;

  // internal source per position; the national bit falls back when the buffer runs dry
  always_comb begin
    if (oh_idx <= IDX_LAST_FAS) begin
      gen_bit = FAS_PATTERN[IDX_LAST_FAS - oh_idx];
    end else if (oh_idx == IDX_A) begin
      gen_bit = cfg_l.alarm;
    end else begin
      gen_bit = cfg_l.nat_bit;
    end
  end

  // mask alters generated values only; data-link bits go out as buffered
  always_comb begin
    if (oh_idx == POS_N[3:0] && cfg_l.nat_dlc && dlc_cnt_q != 4'h0) begin
      int_bit = dlc_sh_q[DLC_W-1];
    end else begin
      int_bit = gen_bit ^ cfg_l.mask[oh_idx];
    end
  end

  // an accepted external value overrides the internal one for that position only
  assign oh_bit = app_q.vld[oh_idx] ? app_q.val[oh_idx] : int_bit;

  // ---- link domain: line output ----

  logic tx_q;

  // registered so the line bit is glitch free; costs one transmit clock of latency
  always_ff @(posedge tx_clk_i) begin
    if (!link_nrst) begin
      tx_q <= 1'b0;
    end else if (is_oh) begin
      tx_q <= oh_bit;
    end else begin
      tx_q <= payload_bit_i;
    end
  end

  assign tx_data_o = tx_q;

endmodule // e3oh_tx_overhead

// *** e3oh_tx_overhead_monitor.sv ***
// Purpose: port-level checks of the e3 transmit overhead block
// Assumes: frame mark and overhead clock seen from the link clock's falling edge
// Notes: pos_q is trusted only after one mark since reset
module e3oh_tx_overhead_monitor (
  input wire logic clk_sys_i, // system clock
  input wire logic nrst_i, // reset, active low
  input wire logic tx_clk_i, // link clock
  input wire logic dlc_valid_i, // data-link byte offered
  input wire logic dlc_ready_o, // data-link room
  input wire logic payload_bit_i, // payload bit in
  input wire logic payload_take_o, // payload slot
  input wire logic tx_data_o, // line bit
  input wire logic overhead_insert_enable_i, // insert enable
  input wire logic overhead_clock_out_o, // overhead clock
  input wire logic overhead_frame_mark_o // frame mark
);
  logic [10:0] pos_q;
  logic seen_q;
  // frame position rebuilt from the mark alone
  always_ff @(posedge tx_clk_i) begin
    pos_q <= overhead_frame_mark_o ? 11'h000 : pos_q + 11'h001;
  end
  // the link leaves reset later than the system side, so wait for a mark
  always_ff @(negedge tx_clk_i) begin
    if (!nrst_i) seen_q <= 1'b0;
    else if (overhead_frame_mark_o) seen_q <= 1'b1;
  end
  mark_single_a: assert property (@(negedge tx_clk_i) disable iff (!nrst_i)
    overhead_frame_mark_o |=> !overhead_frame_mark_o) else $error("frame mark wider than one bit");
  mark_pos_a: assert property (@(negedge tx_clk_i) disable iff (!nrst_i)
    seen_q && overhead_frame_mark_o |-> pos_q == 11'h5ff) else $error("frame mark not on last bit");
  ohclk_window_a: assert property (@(negedge tx_clk_i) disable iff (!nrst_i)
    seen_q |-> overhead_clock_out_o == (overhead_frame_mark_o || pos_q < 11'h00b))
    else $error("overhead clock pulse misplaced");
  ohclk_burst_a: assert property (@(negedge tx_clk_i) disable iff (!nrst_i)
    overhead_frame_mark_o |=> overhead_clock_out_o [*8]) else $error("overhead clock burst broken");
  take_window_a: assert property (@(negedge tx_clk_i) disable iff (!nrst_i)
    seen_q |-> payload_take_o == (pos_q > 11'h00b)) else $error("payload slot misplaced");
  frame_start_a: assert property (@(negedge tx_clk_i) disable iff (!nrst_i)
    overhead_frame_mark_o |=> !payload_take_o [*8]) else $error("payload taken in overhead");
  payload_pass_a: assert property (@(posedge tx_clk_i) disable iff (!nrst_i)
    payload_take_o |=> tx_data_o == $past(payload_bit_i)) else $error("payload bit not passed");
  ready_fall_a: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    $fell(dlc_ready_o) |-> $past(dlc_valid_i)) else $error("buffer full without a push");
  cover property (@(negedge tx_clk_i) overhead_frame_mark_o);
  cover property (@(negedge tx_clk_i) overhead_clock_out_o && overhead_insert_enable_i);
  cover property (@(posedge clk_sys_i) dlc_valid_i && !dlc_ready_o);
endmodule // e3oh_tx_overhead_monitor

// *** e3oh_term_model.sv ***
// Purpose: terminal equipment inserting overhead bits serially
// Assumes: mark is high during the cycle that the coincident clock rise opens
// Notes: lines are scrambled once the insertion burst is over
module e3oh_term_model (
  input wire logic oh_clk_i, // overhead clock from device
  input wire logic mark_i, // frame mark from device
  input wire logic [11:0] ins_en_i, // bits to insert, by rise count
  input wire logic [11:0] ins_val_i, // values to insert
  output logic oh_data_o, // overhead data to device
  output logic oh_ins_o // insert enable to device
);
  int cnt = 0;
  initial begin
    oh_data_o = 1'b0;
    oh_ins_o = 1'b0;
  end
  // count rises since the mark, then set up the bit for the coming fall
  always @(posedge oh_clk_i) begin
    #1;
    cnt = mark_i ? 0 : cnt + 1;
    oh_ins_o = cnt < 12 && ins_en_i[cnt];
    oh_data_o = oh_ins_o ? ins_val_i[cnt] : ~oh_data_o;
  end
  // after the last sample nothing is held, so no stale value lingers
  always @(negedge oh_clk_i) begin
    if (cnt == 11) begin
      #2;
      oh_ins_o = 1'b0;
      oh_data_o = ~oh_data_o;
    end
  end
endmodule // e3oh_term_model

// *** e3oh_tx_overhead_test.sv ***
// Purpose: self-checking bench for the e3 transmit overhead block
// Assumes: insertion allowed on positions 0, 1, 8, 9, 10 and 11 only
// Notes: masks and accept set are mirror-symmetric over the alignment bits
module e3oh_tx_overhead_test;
  import e3oh_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [11:0] ACC = 12'hf03;
  localparam logic [11:0] MASKS [4] = '{12'h000, 12'hfff, 12'h303, 12'hcfc};
  logic clk_sys_i = 1'b0;
  logic tx_clk_i = 1'b0;
  logic nrst_i = 1'b0;
  e3oh_cfg_s cfg_i = '0;
  logic dlc_valid_i = 1'b0;
  logic [7:0] dlc_data_i = 8'h00;
  logic payload_bit_i = 1'b0;
  logic dlc_ready_o, payload_take_o, tx_data_o, overhead_clock_out_o, overhead_frame_mark_o;
  logic overhead_data_in_i, overhead_insert_enable_i;
  logic [11:0] ins_en = 12'h000;
  logic [11:0] ins_val = 12'h000;
  // insertion captured one frame earlier; the bank moves after the overhead it was captured in
  logic [11:0] app_en = 12'h000;
  logic [11:0] app_val = 12'h000;
  logic [11:0] notes [$];
  logic [7:0] dq [$];
  int bi = 0;
  int errors = 0;
  int n_tests = 0;
  int cyc = 0;

  always #10 clk_sys_i = ~clk_sys_i;
  // link clock offset so its edges never line up with the system clock
  initial begin
    #3;
    forever #6 tx_clk_i = ~tx_clk_i;
  end
  always @(negedge tx_clk_i) payload_bit_i <= 1'($urandom);

  e3oh_tx_overhead #(.ACCEPT_MASK(ACC)) e3oh_tx_overhead_inst (.clk_sys_i, .nrst_i, .tx_clk_i, .cfg_i,
    .dlc_valid_i, .dlc_data_i, .dlc_ready_o, .payload_bit_i, .payload_take_o, .tx_data_o,
    .overhead_data_in_i, .overhead_insert_enable_i, .overhead_clock_out_o, .overhead_frame_mark_o);
  e3oh_term_model e3oh_term_model_inst (.oh_clk_i(overhead_clock_out_o), .mark_i(overhead_frame_mark_o),
    .ins_en_i(ins_en), .ins_val_i(ins_val), .oh_data_o(overhead_data_in_i), .oh_ins_o(overhead_insert_enable_i));

  task automatic check(input logic [11:0] seen, input logic [11:0] exp);
    n_tests++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // word bit k is frame position k; a data-link bit is used only when not overridden
  function automatic logic [11:0] expect_oh();
    logic [11:0] e;
    for (int k = 0; k < 10; k++) e[k] = FAS_DEFAULT[9-k] ^ cfg_i.mask[k];
    e[10] = cfg_i.alarm ^ cfg_i.mask[10];
    e[11] = cfg_i.nat_bit ^ cfg_i.mask[11];
    if (cfg_i.nat_dlc && !(app_en[11] && ACC[11]) && dq.size() > 0) begin
      e[11] = dq[0][7-bi];
      bi++;
      if (bi == 8) begin
        bi = 0;
        void'(dq.pop_front());
      end
    end
    for (int k = 0; k < 12; k++) if (app_en[k] && ACC[k]) e[k] = app_val[k];
    return e;
  endfunction

  // valid stays up while full, so refused bytes are offered too
  task automatic fill(input int n);
    repeat (n) begin
      @(negedge clk_sys_i);
      dlc_valid_i = 1'b1;
      dlc_data_i = 8'($urandom);
      if (dlc_ready_o === 1'b1) dq.push_back(dlc_data_i);
    end
    @(negedge clk_sys_i);
    dlc_valid_i = 1'b0;
    check({11'h000, dlc_ready_o}, 12'h000);
  endtask

  // new settings mid-payload, well clear of the overhead window
  task automatic frame(input bit dlc, input int fill_n);
    wait (payload_take_o === 1'b0);
    wait (payload_take_o === 1'b1);
    repeat (50) @(negedge tx_clk_i);
    app_en = ins_en;
    app_val = ins_val;
    cfg_i.mask = MASKS[$urandom % 4];
    cfg_i.alarm = 1'($urandom);
    cfg_i.nat_bit = 1'($urandom);
    cfg_i.nat_dlc = dlc;
    ins_en = 12'($urandom);
    ins_val = 12'($urandom);
    // one forced national override, then none, so the buffer drains within the cycle budget
    if (dlc) ins_en[11] = (fill_n > 0);
    if (fill_n > 0) fill(fill_n);
    notes.push_back(expect_oh());
    @(posedge overhead_frame_mark_o);
  endtask

  // overhead of the frame after each mark, bit 0 two falls later
  initial begin
    logic [11:0] seen;
    forever begin
      @(negedge tx_clk_i);
      if (overhead_frame_mark_o === 1'b1 && notes.size() > 0) begin
        repeat (2) @(negedge tx_clk_i);
        for (int k = 0; k < 12; k++) begin
          seen[k] = tx_data_o;
          @(negedge tx_clk_i);
        end
        check(seen, notes.pop_front());
      end
    end
  end

  always @(posedge clk_sys_i) begin
    cyc++;
    if (cyc == 95000) begin
      errors++;
      $display("mismatch at %0t: timeout", $time);
      report_and_stop();
    end
  end

  initial begin
    void'($urandom(32'hddad));
    repeat (5) @(negedge clk_sys_i);
    nrst_i = 1'b1;
    repeat (8) frame(1'b0, 0);
    $display("test insertion done");
    frame(1'b1, 16);
    while (dq.size() > 0) frame(1'b1, 0);
    repeat (2) frame(1'b1, 0);
    wait (notes.size() == 0);
    repeat (20) @(negedge tx_clk_i);
    check({11'h000, dlc_ready_o}, 12'h001);
    $display("test data link done");
    report_and_stop();
  end
endmodule // e3oh_tx_overhead_test

bind e3oh_tx_overhead e3oh_tx_overhead_monitor e3oh_tx_overhead_monitor_inst (.clk_sys_i, .nrst_i, .tx_clk_i,
  .dlc_valid_i, .dlc_ready_o, .payload_bit_i, .payload_take_o, .tx_data_o, .overhead_insert_enable_i,
  .overhead_clock_out_o, .overhead_frame_mark_o);
